// ==== core/ocfr_avg.sv ====
// Purpose: average current over one sense interval, compare to thresholds
// Assumes: sensePhase high for the interval being averaged
// Notes:   compares sum against threshold times count, so no divider
`include "ocfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ocfr_avg #(
  parameter int SW    = 12,
  parameter int CW    = 8,
  parameter int BLANK = 2
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstLocalN,
  input  wire logic                 sensePhase,
  input  wire logic                 sampleValid,
  input  wire logic signed [SW-1:0] sample,
  input  wire ocfr_pkg::ocfr_fix_t  ocFix,
  input  wire ocfr_pkg::ocfr_fix_t  ucFix,
  output logic                      ocTrip,
  output logic                      ucTrip,
  output logic                      ucLevel
);
  logic signed [SW+CW-1:0] sum;
  logic [CW-1:0]           count;
  logic [CW-1:0]           blank;
  logic                    phaseDly;
  logic signed [SW+CW-1:0] next_sum;
  logic [CW-1:0]           next_count;
  logic [CW-1:0]           next_blank;
  logic                    next_ocTrip;
  logic                    next_ucTrip;
  logic                    next_ucLevel;
  logic signed [47:0]      ocScaled;
  logic signed [47:0]      ucScaled;

  // accumulate unblanked samples, judge at end of interval
  always_comb begin
    next_sum     = sum;
    next_count   = count;
    next_blank   = blank;
    next_ocTrip  = 1'b0;
    next_ucTrip  = 1'b0;
    next_ucLevel = ucLevel;
    ocScaled     = 48'(ocFix) * $signed({1'b0, count});
    ucScaled     = 48'(ucFix) * $signed({1'b0, count});
    if (sensePhase && !phaseDly) begin
      next_sum   = '0;
      next_count = '0;
      next_blank = '0;
    end else if (sensePhase && sampleValid) begin
      if (blank < CW'(BLANK)) begin
        next_blank = blank + CW'(1);
      end else if (count != {CW{1'b1}}) begin
        next_sum   = sum + (SW+CW)'(sample);
        next_count = count + CW'(1);
      end
    end else if (!sensePhase && phaseDly && count != '0) begin
      next_ocTrip  = 48'(sum) > ocScaled;
      next_ucTrip  = 48'(sum) < ucScaled;
      next_ucLevel = next_ucTrip;
    end
  end

  always_ff @(posedge core_clk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      sum      <= '0;
      count    <= '0;
      blank    <= '0;
      phaseDly <= 1'b0;
      ocTrip   <= 1'b0;
      ucTrip   <= 1'b0;
      ucLevel  <= 1'b0;
    end else begin
      sum      <= next_sum;
      count    <= next_count;
      blank    <= next_blank;
      phaseDly <= sensePhase;
      ocTrip   <= next_ocTrip;
      ucTrip   <= next_ucTrip;
      ucLevel  <= next_ucLevel;
    end
  end
endmodule : ocfr_avg
`default_nettype wire

// ==== core/ocfr_cfg.svh ====
// Purpose: named constants for the output current fault response block
// Assumes: 100 MHz core clock
// Notes:   offsets are command codes on the management command port
`ifndef OCFR_CFG_SVH
`define OCFR_CFG_SVH
// ****************************************************************
// command codes
// ****************************************************************
`define OCFR_CMD_UC_ACTION    8'he6
`define OCFR_CMD_AVG_OC_THR   8'he7
`define OCFR_CMD_AVG_UC_THR   8'he8
// ****************************************************************
// field layout and reset value
// ****************************************************************
`define OCFR_UC_ACTION_RESET  8'h80
`define OCFR_RESP_MSB         7
`define OCFR_RESP_LSB         6
`define OCFR_RETRY_MSB        5
`define OCFR_RETRY_LSB        3
`define OCFR_DELAY_MSB        2
`define OCFR_DELAY_LSB        0
`define OCFR_RESP_SHUTDOWN    2'h2
`define OCFR_RESP_WHILE_FAULT 2'h3
`define OCFR_RETRY_FOREVER    3'h7
`define OCFR_EXP_MSB          15
`define OCFR_EXP_LSB          11
`define OCFR_MANT_MSB         10
`define OCFR_MANT_LSB         0
`define OCFR_FRAC_BITS        4
// ****************************************************************
// timing
// ****************************************************************
`define OCFR_CLK_PERIOD_NS    10
`define OCFR_RETRY_UNIT_MS    35
`define OCFR_RETRY_UNIT_CYC   ((`OCFR_RETRY_UNIT_MS * 1000000) / `OCFR_CLK_PERIOD_NS)
`endif

// ==== core/ocfr_pkg.sv ====
// Purpose: types and shared arithmetic for the current fault response block
// Assumes: ocfr_cfg.svh included first
// Notes:   threshold words are 5-bit exponent over 11-bit mantissa
`include "ocfr_cfg.svh"
package ocfr_pkg;
  // ****************************************************************
  // channel state
  // ****************************************************************
  typedef enum logic [3:0] {
    OCFR_RUN     = 4'h1,
    OCFR_LATCHED = 4'h2,
    OCFR_RETRY   = 4'h4,
    OCFR_HOLD    = 4'h8
  } ocfr_state_e;

  typedef logic signed [31:0] ocfr_fix_t;

  // threshold word to signed fixed point amperes
  function automatic ocfr_fix_t ocfrLinToFix(input logic [15:0] word);
    logic signed [4:0]  expo;
    logic signed [10:0] mant;
    logic signed [6:0]  shift;
    ocfr_fix_t          wide;
    expo  = word[`OCFR_EXP_MSB:`OCFR_EXP_LSB];
    mant  = word[`OCFR_MANT_MSB:`OCFR_MANT_LSB];
    shift = 7'(expo) + 7'(`OCFR_FRAC_BITS);
    wide  = 32'(mant);
    if (shift >= 0) begin
      ocfrLinToFix = wide <<< shift;
    end else begin
      ocfrLinToFix = wide >>> (-shift);
    end
  endfunction : ocfrLinToFix

  // negate a threshold word, keeping the most negative mantissa in range
  function automatic logic [15:0] ocfrLinNeg(input logic [15:0] word);
    logic [4:0]  expo;
    logic [10:0] mant;
    expo = word[`OCFR_EXP_MSB:`OCFR_EXP_LSB];
    mant = word[`OCFR_MANT_MSB:`OCFR_MANT_LSB];
    if (mant == 11'h400) begin
      ocfrLinNeg = {5'(expo + 5'h01), 11'h200};
    end else begin
      ocfrLinNeg = {expo, 11'(-mant)};
    end
  endfunction : ocfrLinNeg
endpackage : ocfr_pkg

// ==== core/ocfr_tick.sv ====
// Purpose: retry time base, one pulse per retry unit after a restart
// Assumes: restart is a one-cycle pulse
// Notes:   counting starts again on every restart
`include "ocfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ocfr_tick #(
  parameter int unsigned CYCLES = `OCFR_RETRY_UNIT_CYC
) (
  input  wire logic core_clk,
  input  wire logic rstLocalN,
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_tick;

  // count cycles up to one retry unit
  always_comb begin
    next_count = count + 32'h1;
    next_tick  = 1'b0;
    if (restart) begin
      next_count = 32'h0;
    end else if (count == 32'(CYCLES - 1)) begin
      next_count = 32'h0;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule : ocfr_tick
`default_nettype wire

// ==== core/ocfr_top.sv ====
// Purpose: per-output average current fault detection and response
// Assumes: command port is the decoded management command layer
// Notes:   overcurrent response itself lives outside; a trip pulse is given
`include "ocfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ocfr_top #(
  parameter int NCH        = 2,
  parameter int SW         = 12,
  parameter int CW         = 8,
  parameter int BLANK      = 2,
  parameter int TICK_CYCLES = `OCFR_RETRY_UNIT_CYC
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        cmdValid,
  input  wire logic                        cmdWrite,
  input  wire logic [7:0]                  cmdCode,
  input  wire logic [15:0]                 cmdWdata,
  input  wire logic                        cmdPage,
  input  wire logic                        clearFaults,
  input  wire logic [15:0]                 strapOcThr,
  input  wire logic                        senseUpSlope,
  input  wire logic [NCH-1:0]              pwmHigh,
  input  wire logic [NCH-1:0]              sampleValid,
  input  wire logic [NCH*SW-1:0]           sampleBus,
  input  wire logic [NCH-1:0]              onCommand,
  input  wire logic                        biasGood,
  input  wire logic [NCH-1:0]              otherFault,
  output logic [15:0]                      cmdRdata,
  output logic                             cmdAck,
  output logic                             cmdNack,
  output logic [NCH-1:0]                   outputEnable,
  output logic [NCH-1:0]                   statusUc,
  output logic [NCH-1:0]                   statusOc,
  output logic [NCH-1:0]                   ocResponseTrip,
  output logic                             alert_line_n
);
  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rstSync1;
  logic rstSync2;
  logic rstLocalN;

  // two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  assign rstLocalN = rstSync2;

  // ****************************************************************
  // per-output settings
  // ****************************************************************
  logic [7:0]  ucAction [NCH];
  logic [15:0] ocThr    [NCH];
  logic [15:0] ucThr    [NCH];
  logic        strapDone;
  logic [7:0]  next_ucAction [NCH];
  logic [15:0] next_ocThr    [NCH];
  logic [15:0] next_ucThr    [NCH];
  logic        next_strapDone;
  logic [15:0] next_cmdRdata;
  logic        next_cmdAck;
  logic        next_cmdNack;
  int          sel;

  // command decode, strap load, paged storage
  always_comb begin
    next_ucAction  = ucAction;
    next_ocThr     = ocThr;
    next_ucThr     = ucThr;
    next_strapDone = 1'b1;
    next_cmdRdata  = cmdRdata;
    next_cmdAck    = 1'b0;
    next_cmdNack   = 1'b0;
    sel            = int'(cmdPage);
    if (!strapDone) begin
      for (int c = 0; c < NCH; c++) begin
        next_ocThr[c] = strapOcThr;
        next_ucThr[c] = ocfr_pkg::ocfrLinNeg(strapOcThr);
      end
    end else if (cmdValid) begin
      next_cmdAck = 1'b1;
      unique case (cmdCode)
        `OCFR_CMD_UC_ACTION: begin
          if (cmdWrite) begin
            next_ucAction[sel] = cmdWdata[7:0];
          end
          next_cmdRdata = {8'h00, ucAction[sel]};
        end
        `OCFR_CMD_AVG_OC_THR: begin
          if (cmdWrite) begin
            next_ocThr[sel] = cmdWdata;
          end
          next_cmdRdata = ocThr[sel];
        end
        `OCFR_CMD_AVG_UC_THR: begin
          if (cmdWrite) begin
            next_ucThr[sel] = cmdWdata;
          end
          next_cmdRdata = ucThr[sel];
        end
        default: begin
          next_cmdAck   = 1'b0;
          next_cmdNack  = 1'b1;
          next_cmdRdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      for (int c = 0; c < NCH; c++) begin
        ucAction[c] <= `OCFR_UC_ACTION_RESET;
        ocThr[c]    <= 16'h0000;
        ucThr[c]    <= 16'h0000;
      end
      strapDone <= 1'b0;
      cmdRdata  <= 16'h0000;
      cmdAck    <= 1'b0;
      cmdNack   <= 1'b0;
    end else begin
      ucAction  <= next_ucAction;
      ocThr     <= next_ocThr;
      ucThr     <= next_ucThr;
      strapDone <= next_strapDone;
      cmdRdata  <= next_cmdRdata;
      cmdAck    <= next_cmdAck;
      cmdNack   <= next_cmdNack;
    end
  end

  // ****************************************************************
  // averaging and retry time base
  // ****************************************************************
  logic [NCH-1:0] ocTrip;
  logic [NCH-1:0] ucTrip;
  logic [NCH-1:0] ucLevel;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] tickRestart;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gChan
      // sense interval follows the configured slope
      ocfr_avg #(
        .SW    (SW),
        .CW    (CW),
        .BLANK (BLANK)
      ) uAvg (
        .core_clk    (core_clk),
        .rstLocalN   (rstLocalN),
        .sensePhase  (senseUpSlope ? pwmHigh[g] : !pwmHigh[g]),
        .sampleValid (sampleValid[g]),
        .sample      (sampleBus[g*SW +: SW]),
        .ocFix       (ocfr_pkg::ocfrLinToFix(ocThr[g])),
        .ucFix       (ocfr_pkg::ocfrLinToFix(ucThr[g])),
        .ocTrip      (ocTrip[g]),
        .ucTrip      (ucTrip[g]),
        .ucLevel     (ucLevel[g])
      );
      ocfr_tick #(
        .CYCLES (TICK_CYCLES)
      ) uTick (
        .core_clk  (core_clk),
        .rstLocalN (rstLocalN),
        .restart   (tickRestart[g]),
        .tick      (tick[g])
      );
    end
  endgenerate

  // ****************************************************************
  // response state machine and status
  // ****************************************************************
  ocfr_pkg::ocfr_state_e state [NCH];
  ocfr_pkg::ocfr_state_e next_state [NCH];
  logic [NCH-1:0] attemptOn;
  logic [2:0]     tickCount [NCH];
  logic [NCH-1:0] next_attemptOn;
  logic [2:0]     next_tickCount [NCH];
  logic [NCH-1:0] next_tickRestart;
  logic [NCH-1:0] next_statusUc;
  logic [NCH-1:0] next_statusOc;
  logic [NCH-1:0] next_ocResponseTrip;
  logic [NCH-1:0] next_outputEnable;
  logic [NCH-1:0] stopRetry;
  logic [1:0]     resp;
  logic [2:0]     retry;
  logic [2:0]     delay;

  // per-output fault handling
  always_comb begin
    next_state          = state;
    next_attemptOn      = attemptOn;
    next_tickCount      = tickCount;
    next_tickRestart    = '0;
    next_statusUc       = statusUc;
    next_statusOc       = statusOc;
    next_ocResponseTrip = ocTrip;
    next_outputEnable   = '0;
    resp                = 2'h0;
    retry               = 3'h0;
    delay               = 3'h0;
    for (int c = 0; c < NCH; c++) begin
      resp  = ucAction[c][`OCFR_RESP_MSB:`OCFR_RESP_LSB];
      retry = ucAction[c][`OCFR_RETRY_MSB:`OCFR_RETRY_LSB];
      delay = ucAction[c][`OCFR_DELAY_MSB:`OCFR_DELAY_LSB];
      stopRetry[c] = !onCommand[c] || !biasGood || otherFault[c];
      // clear first so that a same-cycle fault wins
      if (clearFaults) begin
        next_statusUc[c] = 1'b0;
        next_statusOc[c] = 1'b0;
      end
      if (ocTrip[c]) begin
        next_statusOc[c] = 1'b1;
      end
      if (ucTrip[c]) begin
        next_statusUc[c] = 1'b1;
      end
      unique case (state[c])
        ocfr_pkg::OCFR_RUN: begin
          if (ucTrip[c]) begin
            if (resp == `OCFR_RESP_WHILE_FAULT) begin
              next_state[c] = ocfr_pkg::OCFR_HOLD;
            end else if (retry == `OCFR_RETRY_FOREVER) begin
              next_state[c]       = ocfr_pkg::OCFR_RETRY;
              next_attemptOn[c]   = 1'b0;
              next_tickCount[c]   = 3'h0;
              next_tickRestart[c] = 1'b1;
            end else begin
              next_state[c] = ocfr_pkg::OCFR_LATCHED;
            end
          end
        end
        ocfr_pkg::OCFR_LATCHED: begin
          if (clearFaults && !ucTrip[c]) begin
            next_state[c] = ocfr_pkg::OCFR_RUN;
          end
        end
        ocfr_pkg::OCFR_HOLD: begin
          if (!ucLevel[c]) begin
            next_state[c] = ocfr_pkg::OCFR_RUN;
          end
        end
        ocfr_pkg::OCFR_RETRY: begin
          if (stopRetry[c]) begin
            next_state[c]     = ocfr_pkg::OCFR_RUN;
            next_attemptOn[c] = 1'b0;
          end else if (tick[c] && !tickRestart[c]) begin
            if (tickCount[c] == delay) begin
              next_attemptOn[c]   = 1'b1;
              next_tickCount[c]   = 3'h0;
              next_tickRestart[c] = 1'b1;
            end else begin
              next_tickCount[c] = tickCount[c] + 3'h1;
            end
          end else if (ucTrip[c]) begin
            next_attemptOn[c] = 1'b0;
          end
        end
      endcase
      // output drive from the next state
      next_outputEnable[c] = !stopRetry[c] &&
        (next_state[c] == ocfr_pkg::OCFR_RUN ||
         (next_state[c] == ocfr_pkg::OCFR_RETRY && next_attemptOn[c]));
    end
  end

  always_ff @(posedge core_clk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      for (int c = 0; c < NCH; c++) begin
        state[c]     <= ocfr_pkg::OCFR_RUN;
        tickCount[c] <= 3'h0;
      end
      attemptOn      <= '0;
      tickRestart    <= '0;
      statusUc       <= '0;
      statusOc       <= '0;
      ocResponseTrip <= '0;
      outputEnable   <= '0;
      alert_line_n   <= 1'b1;
    end else begin
      state          <= next_state;
      tickCount      <= next_tickCount;
      attemptOn      <= next_attemptOn;
      tickRestart    <= next_tickRestart;
      statusUc       <= next_statusUc;
      statusOc       <= next_statusOc;
      ocResponseTrip <= next_ocResponseTrip;
      outputEnable   <= next_outputEnable;
      alert_line_n   <= !(|next_statusUc || |next_statusOc);
    end
  end
endmodule : ocfr_top
`default_nettype wire

// ==== verif/ocfr_host.sv ====
// Purpose: management host model issuing configuration commands
// Assumes: one-cycle command strobe, answer one cycle later
// Notes:   released data lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module ocfr_host (
  input wire logic  core_clk,
  input wire logic  cmdAck,
  input wire logic  cmdNack,
  input wire logic [15:0] cmdRdata,
  output logic      cmdValid,
  output logic      cmdWrite,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdWdata,
  output logic      cmdPage
);
  // ****************************************************************
  // command transfer
  // ****************************************************************
  // idle bus at time zero
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdWdata = 16'h0000;
    cmdPage  = 1'b0;
  end
  // threshold word kept within plus or minus 100 A
  function automatic logic [15:0] legalThr(input int r);
    int m;
    m = r % 401;
    legalThr = {5'h1e, 11'(m)};
  endfunction : legalThr
  // one strobe, bounded wait for the answer
  task automatic xfer(input logic w, input logic [7:0] c, input logic p,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output logic ack, output logic nack);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdCode  <= c;
    cmdWdata <= wd;
    cmdPage  <= p;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdCode  <= ~c;
    cmdWdata <= ~wd;
    #1;
    for (int k = 0; k < 4; k++) begin
      if (cmdAck || cmdNack) break;
      @(posedge core_clk);
      #1;
    end
    ack  = cmdAck;
    nack = cmdNack;
    rd   = cmdRdata;
  endtask : xfer
endmodule : ocfr_host
`default_nettype wire

// ==== verif/ocfr_top_chk.sv ====
// Purpose: port-level checks for the current fault response block
// Assumes: single clock domain, rst_n active low
// Notes:   bound into every ocfr_top instance
`timescale 1ns/1ps
`default_nettype none
module ocfr_top_chk #(
  parameter int NCH = 2
) (
  input wire logic           core_clk,
  input wire logic           rst_n,
  input wire logic           cmdValid,
  input wire logic [7:0]     cmdCode,
  input wire logic           clearFaults,
  input wire logic [NCH-1:0] onCommand,
  input wire logic           biasGood,
  input wire logic [15:0]    cmdRdata,
  input wire logic           cmdAck,
  input wire logic           cmdNack,
  input wire logic [NCH-1:0] outputEnable,
  input wire logic [NCH-1:0] statusUc,
  input wire logic [NCH-1:0] statusOc,
  input wire logic [NCH-1:0] ocResponseTrip,
  input wire logic           alert_line_n
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // command steps and bias loss
  sequence knownCmd;
    cmdValid && (cmdCode inside {8'he6, 8'he7, 8'he8});
  endsequence
  sequence unknownCmd;
    cmdValid && !(cmdCode inside {8'he6, 8'he7, 8'he8});
  endsequence
  sequence biasLost;
    !biasGood ##1 !biasGood;
  endsequence
  alert_level_a: assert property (alert_line_n == !(|{statusUc, statusOc}))
    else $error("alert line does not follow status");
  uc_sticky_a: assert property (!$past(clearFaults) && !$past(clearFaults, 2)
    |-> (($past(statusUc) & ~statusUc) == '0)) else $error("uc status lost");
  oc_sticky_a: assert property (!$past(clearFaults) && !$past(clearFaults, 2)
    |-> (($past(statusOc) & ~statusOc) == '0)) else $error("oc status lost");
  uc_disable_a: assert property (((statusUc & ~$past(statusUc) & outputEnable)) == '0)
    else $error("output on while uc fault sets");
  oc_trip_a: assert property ((ocResponseTrip & ~statusOc) == '0)
    else $error("oc trip without oc status");
  cmd_known_a: assert property (knownCmd |=> cmdAck && !cmdNack)
    else $error("known command not acknowledged");
  cmd_refuse_a: assert property (unknownCmd |=> cmdNack && !cmdAck && cmdRdata == '0)
    else $error("unknown command not refused");
  bias_off_a: assert property (biasLost |-> outputEnable == '0)
    else $error("output on without bias");
  enable_cause_a: assert property ((outputEnable & ~$past(outputEnable)
    & ~($past(onCommand) & {NCH{$past(biasGood)}})) == '0) else $error("enable without cause");
endmodule : ocfr_top_chk
bind ocfr_top ocfr_top_chk #(.NCH(NCH)) i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .clearFaults(clearFaults), .onCommand(onCommand),
  .biasGood(biasGood), .cmdRdata(cmdRdata), .cmdAck(cmdAck), .cmdNack(cmdNack),
  .outputEnable(outputEnable), .statusUc(statusUc), .statusOc(statusOc),
  .ocResponseTrip(ocResponseTrip), .alert_line_n(alert_line_n));
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the current fault response block
// Assumes: retry unit shortened to 20 cycles, samples are amps times 16
// Notes:   random thresholds and delays from a fixed seed
`include "ocfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0]  ACT = `OCFR_CMD_UC_ACTION;
  localparam logic [7:0]  OCT = `OCFR_CMD_AVG_OC_THR;
  localparam logic [7:0]  UCT = `OCFR_CMD_AVG_UC_THR;
  localparam logic [15:0] STRAP = 16'hf190;
  localparam logic [15:0] UC10  = 16'hf028;
  localparam logic [17:0] DFLT  = {2'b10, 8'h00, `OCFR_UC_ACTION_RESET};
  logic        core_clk = 1'b0, rst_n = 1'b0, clearFaults = 1'b0, senseUpSlope = 1'b0;
  logic        biasGood = 1'b1, cmdValid, cmdWrite, cmdPage, cmdAck, cmdNack, alert_line_n;
  logic [1:0]  pwmHigh = 2'h0, sampleValid = 2'h0, onCommand = 2'h3;
  logic [1:0]  outputEnable, statusUc, statusOc, ocResponseTrip;
  logic [23:0] sampleBus = 24'h0;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWdata, cmdRdata;
  int          seed = 32'hbad495d6, n_mismatch = 0, total_checks = 0, ocPulses = 0;
  // ****************************************************************
  // clock, instances, monitors
  // ****************************************************************
  always #5 core_clk = ~core_clk;
  ocfr_top #(.TICK_CYCLES(20)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
    .cmdPage(cmdPage), .clearFaults(clearFaults), .strapOcThr(STRAP),
    .senseUpSlope(senseUpSlope), .pwmHigh(pwmHigh), .sampleValid(sampleValid),
    .sampleBus(sampleBus), .onCommand(onCommand), .biasGood(biasGood),
    .otherFault(2'h0), .cmdRdata(cmdRdata), .cmdAck(cmdAck), .cmdNack(cmdNack),
    .outputEnable(outputEnable), .statusUc(statusUc), .statusOc(statusOc),
    .ocResponseTrip(ocResponseTrip), .alert_line_n(alert_line_n));
  ocfr_host i_host (.core_clk(core_clk), .cmdAck(cmdAck), .cmdNack(cmdNack),
    .cmdRdata(cmdRdata), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWdata(cmdWdata), .cmdPage(cmdPage));
  // count overcurrent trip pulses on channel 1
  always @(posedge core_clk) if (ocResponseTrip[1] === 1'b1) ocPulses <= ocPulses + 1;
  // hang guard
  initial begin
    #300000;
    n_mismatch++;
    print_verdict();
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  function automatic logic [15:0] negLin(input logic [15:0] w);
    negLin = {w[15:11], 11'(-w[10:0])};
  endfunction : negLin
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [7:0] c, input logic p,
                     input logic [15:0] wd, input logic [17:0] exp);
    logic [15:0] rd;
    logic        ack, nack;
    i_host.xfer(w, c, p, wd, rd, ack, nack);
    cmp({2'b00, ack, nack, rd}, {2'b00, exp});
  endtask : acc
  // two blanked samples then four counted ones
  task automatic runInterval(input int ch, input logic up, input logic [11:0] bv, dv);
    @(posedge core_clk);
    senseUpSlope <= up;
    pwmHigh[ch]  <= !up;
    repeat (2) @(posedge core_clk);
    pwmHigh[ch] <= up;
    for (int k = 0; k < 12; k++) begin
      @(posedge core_clk);
      sampleValid[ch]        <= !k[0];
      sampleBus[ch*12 +: 12] <= (k < 4) ? bv : dv;
    end
    @(posedge core_clk);
    pwmHigh[ch] <= !up;
    repeat (5) @(posedge core_clk);
  endtask : runInterval
  task automatic clear();
    @(posedge core_clk);
    clearFaults <= 1'b1;
    @(posedge core_clk);
    clearFaults <= 1'b0;
  endtask : clear
  task automatic waitFor(input int ch, input logic v, output int n);
    n = 0;
    while (outputEnable[ch] !== v && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : waitFor
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [15:0] r0;
    int          n;
    int          d;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    cmp({alert_line_n, statusUc, statusOc, outputEnable}, 20'h43);
    acc(1'b0, ACT, 1'b0, 16'h0, DFLT);
    acc(1'b0, ACT, 1'b1, 16'h0, DFLT);
    acc(1'b0, OCT, 1'b1, 16'h0, {2'b10, STRAP});
    acc(1'b0, UCT, 1'b0, 16'h0, {2'b10, negLin(STRAP)});
    r0 = i_host.legalThr($random(seed));
    acc(1'b1, OCT, 1'b0, r0, {2'b10, STRAP});
    acc(1'b0, OCT, 1'b1, 16'h0, {2'b10, STRAP});
    acc(1'b1, OCT, 1'b0, STRAP, {2'b10, r0});
    acc(1'b1, 8'he9, 1'b0, 16'h1234, 18'h10000);
    acc(1'b1, ACT, 1'b1, 16'hff80, DFLT);
    acc(1'b0, ACT, 1'b1, 16'h0, DFLT);
    acc(1'b1, UCT, 1'b0, UC10, {2'b10, negLin(STRAP)});
    runInterval(0, 1'b0, 12'd1600, 12'($random(seed) & 127));
    cmp({alert_line_n, statusUc, statusOc, outputEnable}, 20'h12);
    repeat (300) @(posedge core_clk);
    cmp({statusUc, outputEnable}, 20'h6);
    clear();
    waitFor(0, 1'b1, n);
    cmp({alert_line_n, statusUc}, 20'h4);
    acc(1'b1, ACT, 1'b0, 16'h00c0, DFLT);
    runInterval(0, 1'b0, 12'd0, 12'($random(seed) & 127));
    cmp(outputEnable, 20'h2);
    runInterval(0, 1'b0, 12'd0, 12'd200 + 12'($random(seed) & 255));
    waitFor(0, 1'b1, n);
    cmp({statusUc, outputEnable}, 20'h7);
    clear();
    d = $random(seed) & 7;
    acc(1'b1, ACT, 1'b0, {10'h2, 3'h7, 3'(d)}, {2'b10, 16'h00c0});
    runInterval(0, 1'b0, 12'd0, 12'd0);
    waitFor(0, 1'b1, n);
    cmp(20'(n >= (d + 1) * 20 - 4 && n <= (d + 1) * 20 + 4), 20'h1);
    @(posedge core_clk);
    biasGood <= 1'b0;
    repeat (3) @(posedge core_clk);
    cmp(outputEnable, 20'h0);
    biasGood <= 1'b1;
    waitFor(0, 1'b1, n);
    cmp(statusUc, 20'h1);
    acc(1'b1, OCT, 1'b1, UC10, {2'b10, STRAP});
    runInterval(1, 1'b1, 12'd2000, 12'd100);
    cmp(statusOc, 20'h0);
    runInterval(1, 1'b1, 12'd0, 12'd200 + 12'($random(seed) & 255));
    cmp({statusOc, statusUc, 12'(ocPulses)}, {4'h0, 2'b10, 2'b01, 12'h1});
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
